/* design/five_port_io_pkg.sv */
package five_port_io_pkg;

  typedef logic [4:0][7:0] port_bits_t;

  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;

  // register indices; the byte address is four times the index
  localparam logic [3:0] IDX_A_LATCH = 4'h0;
  localparam logic [3:0] IDX_B_LATCH = 4'h1;
  localparam logic [3:0] IDX_C_LATCH = 4'h2;
  localparam logic [3:0] IDX_D_LATCH = 4'h3;
  localparam logic [3:0] IDX_A_DIR = 4'h4;
  localparam logic [3:0] IDX_B_DIR = 4'h5;
  localparam logic [3:0] IDX_C_DIR = 4'h6;
  localparam logic [3:0] IDX_D_DIR = 4'h7;
  localparam logic [3:0] IDX_E_LATCH = 4'h8;
  localparam logic [3:0] IDX_E_DIR = 4'hc;
  localparam logic [3:0] IDX_A_PULL = 4'hd;
  localparam logic [3:0] IDX_C_PULL = 4'he;
  localparam logic [3:0] IDX_D_PULL = 4'hf;

  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 5;

  // implemented pins per port, element [4] is port E
  localparam port_bits_t PIN_MASK = {8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff};
  localparam port_bits_t PULL_MASK = {8'h00, 8'hff, 8'h7f, 8'h00, 8'hff};
  localparam logic [7:0] C_LATCH_READ_ONES = 8'h80;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [7:0] NUM_CHANNEL_PINS = 8'h08;

  typedef enum logic [1:0] {
    KIND_LATCH = 2'b00,
    KIND_DIR = 2'b01,
    KIND_PULL = 2'b10
  } reg_kind_e;

  typedef struct packed {
    logic hit;
    reg_kind_e kind;
    logic [2:0] port;
  } reg_sel_s;

  typedef struct packed {
    logic [7:0] keypad_irq_enable;
    logic [4:0] converter_channel_select;
    logic controller_area_enable;
    logic serial_periph_on;
    logic [3:0][1:0] timer_edge_level_select;
    logic async_serial_enable;
  } periph_ctrl_s;

  typedef struct packed {
    port_bits_t dir;
    port_bits_t pull;
    port_bits_t sync1;
    port_bits_t sync2;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic rd_pend;
    logic [3:0] rd_idx;
    logic [31:0] rdata;
    logic first;
  } state_s;

endpackage

/* design/five_port_parallel_io.sv */
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module five_port_parallel_io
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire five_port_io_pkg::periph_ctrl_s periph_ctrl,
  input wire five_port_io_pkg::port_bits_t periph_out,
  input wire five_port_io_pkg::port_bits_t periph_dir,
  input wire five_port_io_pkg::port_bits_t pad_in,
  output logic [4:0][7:0] pad_out,
  output logic [4:0][7:0] pad_oe_n,
  output logic [4:0][7:0] pad_pull_on,
  output logic [4:0][7:0] pad_level
);
  import five_port_io_pkg::*;

  state_s st_ff;
  state_s nxt_st;
  port_bits_t latch_ff;
  port_bits_t nxt_latch;
  port_bits_t own;
  port_bits_t eff_dir;
  reg_sel_s wsel;
  reg_sel_s rsel;
  logic ap_valid;
  logic addr_ok;
  logic [3:0] ap_idx;
  logic [3:0] timer_on;

  function automatic reg_sel_s decode_reg(input logic [3:0] idx);
    reg_sel_s s;
    s.hit = 1'b1;
    s.kind = KIND_LATCH;
    s.port = PORT_A;
    unique case (idx)
      IDX_A_LATCH: s.port = PORT_A;
      IDX_B_LATCH: s.port = PORT_B;
      IDX_C_LATCH: s.port = PORT_C;
      IDX_D_LATCH: s.port = PORT_D;
      IDX_E_LATCH: s.port = PORT_E;
      IDX_A_DIR:
      begin
        s.kind = KIND_DIR;
        s.port = PORT_A;
      end
      IDX_B_DIR:
      begin
        s.kind = KIND_DIR;
        s.port = PORT_B;
      end
      IDX_C_DIR:
      begin
        s.kind = KIND_DIR;
        s.port = PORT_C;
      end
      IDX_D_DIR:
      begin
        s.kind = KIND_DIR;
        s.port = PORT_D;
      end
      IDX_E_DIR:
      begin
        s.kind = KIND_DIR;
        s.port = PORT_E;
      end
      IDX_A_PULL:
      begin
        s.kind = KIND_PULL;
        s.port = PORT_A;
      end
      IDX_C_PULL:
      begin
        s.kind = KIND_PULL;
        s.port = PORT_C;
      end
      IDX_D_PULL:
      begin
        s.kind = KIND_PULL;
        s.port = PORT_D;
      end
      default: s.hit = 1'b0;
    endcase
    return s;
  endfunction

  // value a register read returns; unimplemented bits come from the masks, except port C latch bit 7, which reads as one
  function automatic logic [7:0] reg_value(input reg_sel_s s, input port_bits_t dir,
                                           input port_bits_t pull, input port_bits_t lat,
                                           input port_bits_t pins);
    logic [7:0] v;
    v = 8'h00;
    if (s.hit)
    begin
      unique case (s.kind)
        KIND_LATCH:
        begin
          v = ((lat[s.port] & dir[s.port]) | (pins[s.port] & ~dir[s.port])) & PIN_MASK[s.port];
          if (s.port == PORT_C)
            v = v | C_LATCH_READ_ONES;
        end
        KIND_DIR: v = dir[s.port] & PIN_MASK[s.port];
        KIND_PULL: v = pull[s.port] & PULL_MASK[s.port];
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  function automatic logic [7:0] channel_onehot(input logic [4:0] ch);
    logic [7:0] m;
    m = 8'h00;
    if ({3'h0, ch} < NUM_CHANNEL_PINS)
      m = 8'h01 << ch[2:0];
    return m;
  endfunction

  // every transfer is answered in one cycle, so the slave never stalls
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign pad_level = st_ff.sync2;

  assign ap_valid = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:ADDR_IDX_MSB+1] == '0) && (haddr[1:0] == 2'b00);
  assign ap_idx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  assign wsel = decode_reg(st_ff.wr_idx);
  assign rsel = decode_reg(ap_idx);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_latch = latch_ff;
    nxt_st.first = 1'b0;
    nxt_st.sync1 = pad_in;
    nxt_st.sync2 = st_ff.sync1;
    if (st_ff.wr_pend && wsel.hit)
    begin
      unique case (wsel.kind)
        // latch takes the write whatever the direction
        KIND_LATCH: nxt_latch[wsel.port] = hwdata[7:0] & PIN_MASK[wsel.port];
        KIND_DIR: nxt_st.dir[wsel.port] = hwdata[7:0] & PIN_MASK[wsel.port];
        KIND_PULL: nxt_st.pull[wsel.port] = hwdata[7:0] & PULL_MASK[wsel.port];
        default: nxt_st.dir = st_ff.dir;
      endcase
    end
    nxt_st.wr_pend = ap_valid && hwrite && addr_ok;
    nxt_st.wr_idx = ap_idx;
    nxt_st.rd_pend = ap_valid && !hwrite;
    nxt_st.rd_idx = ap_idx;
    if (ap_valid && !hwrite)
    begin
      // read from post-write values so a read right behind a write sees it
      nxt_st.rdata = RDATA_RESET;
      if (addr_ok)
        nxt_st.rdata[7:0] = reg_value(rsel, nxt_st.dir, nxt_st.pull, nxt_latch, st_ff.sync2);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff.dir <= {5{DIR_RESET}};
      st_ff.pull <= {5{PULL_RESET}};
      st_ff.sync1 <= '0;
      st_ff.sync2 <= '0;
      st_ff.wr_pend <= 1'b0;
      st_ff.wr_idx <= 4'h0;
      st_ff.rd_pend <= 1'b0;
      st_ff.rd_idx <= 4'h0;
      st_ff.rdata <= RDATA_RESET;
      st_ff.first <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // no reset here: the latches hold their value through it
  always_ff @(posedge hclk)
  begin
    latch_ff <= nxt_latch;
  end

  // pin ownership by the sharing peripherals
  genvar t;
  generate
    for (t = 0; t < 4; t++)
    begin : g_timer
      assign timer_on[t] = |periph_ctrl.timer_edge_level_select[t];
    end
  endgenerate

  assign own[PORT_A] = periph_ctrl.keypad_irq_enable;
  assign own[PORT_B] = channel_onehot(periph_ctrl.converter_channel_select);
  assign own[PORT_C] = {6'h00, {2{periph_ctrl.controller_area_enable}}};
  assign own[PORT_D] = {timer_on, {4{periph_ctrl.serial_periph_on}}};
  assign own[PORT_E] = {6'h00, {2{periph_ctrl.async_serial_enable}}};

  genvar p;
  generate
    for (p = 0; p < 5; p++)
    begin : g_port
      assign eff_dir[p] = ((own[p] & periph_dir[p]) | (~own[p] & st_ff.dir[p])) & PIN_MASK[p];
      assign pad_oe_n[p] = ~eff_dir[p];
      assign pad_out[p] = ((own[p] & periph_out[p]) | (~own[p] & st_ff.dir[p] & latch_ff[p]))
                          & PIN_MASK[p];
      assign pad_pull_on[p] = st_ff.pull[p] & ~eff_dir[p] & PULL_MASK[p];
    end
  endgenerate

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_DIR_TO_PIN: assert property (
    st_ff.wr_pend && st_ff.wr_idx == IDX_A_DIR && periph_ctrl.keypad_irq_enable == 8'h00
    ##1 periph_ctrl.keypad_irq_enable == 8'h00 |-> pad_oe_n[0] == ~$past(hwdata[7:0]))
    else $error("direction write did not reach port A enables");

  AST_PULL_ON_INPUT: assert property (
    st_ff.wr_pend && st_ff.wr_idx == IDX_D_PULL |=>
    (eff_dir[3] == 8'h00) |-> pad_pull_on[3] == $past(hwdata[7:0]))
    else $error("port D pullup enable not applied on inputs");

  AST_PULL_OFF_OUTPUT: assert property (
    (pad_pull_on & ~pad_oe_n) == '0)
    else $error("pullup active on a driven pin");

  AST_PULL_RESTORED: assert property (
    $fell(eff_dir[0][0]) && st_ff.pull[0][0] |-> pad_pull_on[0][0])
    else $error("pullup not restored on return to input");

  AST_MAP_E_DIR: assert property (
    ap_valid && !hwrite && haddr == 32'h0000_0030 && !st_ff.wr_pend |=>
    hrdata == {24'h0, st_ff.dir[4]})
    else $error("port E direction not at its address");

  AST_RESET_STATE: assert property (
    st_ff.first |-> st_ff.dir == '0 && st_ff.pull == '0 && pad_pull_on == '0)
    else $error("direction or pullup not cleared by reset");

  AST_C_TOP_BIT: assert property (
    ap_valid && !hwrite && haddr == 32'h0000_0008 |=> hrdata[7:0] >= 8'h80 && hrdata[31:8] == '0)
    else $error("port C bit 7 does not read as one");

  AST_E_TOP_BITS: assert property (
    ap_valid && !hwrite && (haddr == 32'h0000_0020 || haddr == 32'h0000_0030) |=>
    hrdata[7:6] == 2'b00)
    else $error("port E bits 7 and 6 not zero");

  AST_OWNER_DRIVES: assert property (
    periph_ctrl.async_serial_enable |-> pad_out[4][1:0] == periph_out[4][1:0]
    && pad_oe_n[4][1:0] == ~periph_dir[4][1:0])
    else $error("serial port does not own its pins");

  AST_READ_OUTPUT_LATCH: assert property (
    ap_valid && !hwrite && haddr == 32'h0000_0004 && !st_ff.wr_pend && st_ff.dir[1] == 8'hff
    |=> hrdata[7:0] == latch_ff[1])
    else $error("output pin read did not return the latch");

  AST_LATCH_WRITE: assert property (
    st_ff.wr_pend && st_ff.wr_idx == IDX_B_LATCH |=> latch_ff[1] == $past(hwdata[7:0]))
    else $error("latch write lost");

  // latch retention through reset is left to the bench: reset disables these checks
  AST_READ_INPUT_PIN: assert property (
    ap_valid && !hwrite && haddr == 32'h0000_0000 && !st_ff.wr_pend && st_ff.dir[0] == 8'h00
    |=> hrdata[7:0] == $past(st_ff.sync2[0]))
    else $error("input pin read did not return the pin level");

  AST_RDATA_STANDS: assert property (
    !(ap_valid && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  AST_PULL_FOLLOWS: assert property (
    !periph_ctrl.controller_area_enable && st_ff.dir[2] == 8'h00
    |-> pad_pull_on[2] == st_ff.pull[2])
    else $error("port C pullup enable not applied on inputs");

  AST_NO_PULL_B_E: assert property (
    pad_pull_on[1] == 8'h00 && pad_pull_on[4] == 8'h00)
    else $error("pullup on a port without pullups");

  AST_C_CTRL_TOP_BIT: assert property (
    ap_valid && !hwrite && (haddr == 32'h0000_0018 || haddr == 32'h0000_0038) |=>
    !hrdata[7])
    else $error("port C control bit 7 does not read as zero");

  AST_E_PIN_IDLE: assert property (
    pad_oe_n[4][7:6] == 2'b11 && pad_out[4][7:6] == 2'b00)
    else $error("absent port E pins are driven");

  AST_RELEASED_E: assert property (
    !periph_ctrl.async_serial_enable |-> pad_oe_n[4] == ~st_ff.dir[4])
    else $error("port E direction not back under register control");

  AST_KEYPAD_OWNS: assert property (
    periph_ctrl.keypad_irq_enable[7] |-> pad_oe_n[0][7] == ~periph_dir[0][7]
    && pad_out[0][7] == periph_out[0][7])
    else $error("keypad does not own its pin");

  AST_CONVERTER_OWNS: assert property (
    periph_ctrl.converter_channel_select == 5'h03 |-> pad_oe_n[1][3] == ~periph_dir[1][3])
    else $error("converter does not own its selected pin");

  AST_OUTPUT_DRIVES_LATCH: assert property (
    periph_ctrl.keypad_irq_enable == 8'h00 && st_ff.dir[0] == 8'hff
    |-> pad_out[0] == latch_ff[0])
    else $error("port A outputs do not show the latch");

  COV_DIR_WRITE: cover property (st_ff.wr_pend && st_ff.wr_idx == IDX_A_DIR);
  COV_PULL_RESTORE: cover property ($fell(eff_dir[0][0]) && st_ff.pull[0][0]);
  COV_BACK_TO_BACK: cover property (st_ff.wr_pend ##1 st_ff.rd_pend);
  COV_OWNED: cover property (periph_ctrl.serial_periph_on && st_ff.dir[3] != 8'h00);
  COV_CONVERTER: cover property (periph_ctrl.converter_channel_select == 5'h03);

endmodule // five_port_parallel_io

`default_nettype wire

/* dv/io_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module io_far_side
(
  input wire logic hclk,
  input wire five_port_io_pkg::port_bits_t pad_out,
  input wire five_port_io_pkg::port_bits_t pad_oe_n,
  input wire five_port_io_pkg::port_bits_t pad_pull_on,
  input wire five_port_io_pkg::port_bits_t ext_en,
  input wire five_port_io_pkg::port_bits_t ext_val,
  input wire logic [5:0] own,
  output var five_port_io_pkg::port_bits_t pad_in,
  output var five_port_io_pkg::periph_ctrl_s periph_ctrl,
  output var five_port_io_pkg::port_bits_t periph_out,
  output var five_port_io_pkg::port_bits_t periph_dir
);
  import five_port_io_pkg::*;
  logic flip_ff;
  initial flip_ff = 1'b0;
  // a floating pin wanders, so an unknown never settles to a lucky value
  always @(posedge hclk) flip_ff <= ~flip_ff;
  always_comb
  begin
    for (int p = 0; p < 5; p++)
      for (int b = 0; b < 8; b++)
        if (!pad_oe_n[p][b]) pad_in[p][b] = pad_out[p][b];
        else if (ext_en[p][b]) pad_in[p][b] = ext_val[p][b];
        else if (pad_pull_on[p][b]) pad_in[p][b] = 1'b1;
        else pad_in[p][b] = flip_ff ^ b[0];
  end
  always_comb
  begin
    periph_ctrl = '0;
    periph_ctrl.keypad_irq_enable = own[0] ? 8'h81 : 8'h00;
    periph_ctrl.converter_channel_select = own[1] ? 5'h03 : 5'h08;
    periph_ctrl.controller_area_enable = own[2];
    periph_ctrl.serial_periph_on = own[3];
    periph_ctrl.timer_edge_level_select[1] = own[4] ? 2'h1 : 2'h0;
    periph_ctrl.async_serial_enable = own[5];
  end
  // keypad and converter only listen; the others drive their pins
  assign periph_dir = {8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
  assign periph_out = {5{8'h5a}};
endmodule // io_far_side
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import five_port_io_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  periph_ctrl_s periph_ctrl;
  port_bits_t periph_out, periph_dir, pad_in, pad_out, pad_oe_n, pad_pull_on, pad_level;
  port_bits_t ext_en = '0;
  port_bits_t ext_val = '0;
  logic [5:0] own = 6'h0;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] r;
  logic [3:0] ctl_idx [8] = '{IDX_A_DIR, IDX_B_DIR, IDX_C_DIR, IDX_D_DIR, IDX_E_DIR,
                              IDX_A_PULL, IDX_C_PULL, IDX_D_PULL};
  logic [7:0] ctl_mask [8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'hff};
  int own_port [6] = '{0, 1, 2, 3, 3, 4};
  logic [7:0] own_mask [6] = '{8'h81, 8'h08, 8'h03, 8'h0f, 8'h20, 8'h03};
  always #12.5 hclk = ~hclk;
  five_port_parallel_io five_port_parallel_io_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .periph_ctrl(periph_ctrl), .periph_out(periph_out), .periph_dir(periph_dir),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_on(pad_pull_on),
    .pad_level(pad_level));
  io_far_side io_far_side_i (.hclk(hclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_on(pad_pull_on), .ext_en(ext_en), .ext_val(ext_val), .own(own),
    .pad_in(pad_in), .periph_ctrl(periph_ctrl), .periph_out(periph_out),
    .periph_dir(periph_dir));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    chk(r[7:0], exp, what);
    chk(r[31:24] | r[23:16] | r[15:8], 8'h00, "upper read bits");
    chk({7'h00, hresp}, 8'h00, "bus response");
  endtask
  // pins pass two sync flops, so give them time before looking
  task automatic settle;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk(pad_oe_n[0] & pad_oe_n[2] & pad_oe_n[4], 8'hff, "oe after reset");
    chk(pad_pull_on[0] | pad_pull_on[3], 8'h00, "pull after reset");
    for (int k = 0; k < 8; k++)
      rd(ctl_idx[k], 8'h00, "reset value");
    for (int k = 0; k < 8; k++)
      wr(ctl_idx[k], 8'hf0 | 8'(k));
    for (int k = 0; k < 8; k++)
      rd(ctl_idx[k], (8'hf0 | 8'(k)) & ctl_mask[k], "map readback");
    rd(4'h9, 8'h00, "unmapped read");
    for (int k = 0; k < 8; k++)
      wr(ctl_idx[k], 8'h00);
    $display("test map done");
    @(posedge hclk);
    ext_en[0] <= 8'hff;
    ext_val[0] <= 8'h3c;
    wr(IDX_A_LATCH, 8'ha5);
    settle();
    chk(pad_oe_n[0], 8'hff, "latch write kept off pin");
    rd(IDX_A_LATCH, 8'h3c, "input reads pin");
    chk(pad_level[0], 8'h3c, "level to peripherals");
    wr(IDX_A_DIR, 8'h0f);
    settle();
    rd(IDX_A_LATCH, 8'h35, "mixed read");
    chk(pad_oe_n[0], 8'hf0, "per bit direction");
    chk(pad_out[0] & 8'h0f, 8'h05, "latch on pin");
    $display("test direction done");
    @(posedge hclk);
    ext_en[0] <= 8'h00;
    wr(IDX_A_PULL, 8'hff);
    settle();
    chk(pad_pull_on[0], 8'hf0, "pull off on outputs");
    chk(pad_pull_on[1], 8'h00, "no pull on port b");
    rd(IDX_A_LATCH, 8'hf5, "pulled inputs");
    wr(IDX_A_DIR, 8'h00);
    settle();
    chk(pad_pull_on[0], 8'hff, "pull restored");
    $display("test pullup done");
    wr(IDX_C_DIR, 8'h7f);
    wr(IDX_C_LATCH, 8'h2a);
    rd(IDX_C_LATCH, 8'haa, "port c top bit");
    wr(IDX_E_DIR, 8'hff);
    wr(IDX_E_LATCH, 8'hff);
    rd(IDX_E_LATCH, 8'h3f, "port e top bits");
    settle();
    chk(pad_oe_n[4], 8'hc0, "port e absent pins");
    $display("test narrow ports done");
    wr(IDX_B_LATCH, 8'h96);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_B_DIR, 8'h00, "dir after second reset");
    wr(IDX_B_DIR, 8'hff);
    wr(IDX_A_DIR, 8'hff);
    wr(IDX_D_LATCH, 8'h00);
    // port D bit 7 stands for an unbonded pin, kept as an output so it never floats
    wr(IDX_D_DIR, 8'h80);
    rd(IDX_B_LATCH, 8'h96, "latch kept");
    chk(pad_oe_n[3], 8'h7f, "unbonded pin driven");
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      @(posedge hclk);
      own <= 6'h01 << k;
      settle();
      chk(pad_oe_n[own_port[k]] & own_mask[k], own_port[k] < 2 ? own_mask[k] : 8'h00,
          "owned direction");
      // owned pins carry the peripheral's value even where it only listens
      chk(pad_out[own_port[k]] & own_mask[k], 8'h5a & own_mask[k],
          "owned value");
      @(posedge hclk);
      own <= 6'h00;
      settle();
      chk(pad_oe_n[own_port[k]] & own_mask[k], own_port[k] < 2 ? 8'h00 : own_mask[k],
          "released");
    end
    $display("test sharing done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
